// ==== logic/dgl_pin_mapper.sv ====
// General-purpose pin logic with forward and back-channel signal mapping.
`timescale 1ns/100ps
module dgl_pin_mapper #(
   parameter logic [6:0] DEV_ADDR = 7'h30
) (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // Serial control pins.
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output      logic        sda_out,
   output      logic        sda_oe,
   // General-purpose pins.
   input  wire logic [7:0]  pin_in,
   output      logic [7:0]  pin_out,
   output      logic [7:0]  pin_oe,
   output      logic [7:0]  pin_input_en,
   output      logic [7:0]  pin_pulldown_en,
   // Forward-channel values, four per receive port, port-major.
   input  wire logic [15:0] fwd_gpio,
   // Frame sync and other internal sources.
   input  wire logic        frame_sync_pulse,
   input  wire logic        frame_sync_ext,
   input  wire logic        internal_ctrl,
   // Back channel, four slots per receive port, port-major.
   input  wire logic [3:0]  bc_frame_strobe,
   output      logic [15:0] bc_gpio
);

   dgl_pkg::dgl_reg_req_type reg_req;
   logic [7:0]               rd_addr;
   logic [7:0]               reg_rdata;
   logic [7:0]               input_disable;
   logic [7:0]               pulldown_disable;
   logic [7:0]               pin_ctl [0:7];
   logic [7:0]               slot_map [0:7];
   logic [1:0]               port_select;
   logic [7:0]               pin_level_status;
   logic [7:0]               next_pin_out;
   logic [7:0]               next_pin_oe;
   logic [7:0]               next_pin_input_en;
   logic [7:0]               next_pin_pulldown_en;
   logic [15:0]              next_bc_gpio;
   wire                      wr_input;
   wire                      wr_pulldown;
   wire                      wr_port_sel;
   wire                      wr_pin_ctl;
   wire                      wr_slot_lo;
   wire                      wr_slot_hi;
   localparam logic [7:0]    OD_MASK = 8'h01 << dgl_pkg::OPEN_DRAIN_PIN;

   // Output value of a pin from its selected source.
   function automatic logic pin_value(input logic [1:0] src, input logic reg_val,
                                      input logic fwd, input logic fsync,
                                      input logic ctrl);
      unique case (dgl_pkg::dgl_src_type'(src))
         dgl_pkg::SRC_REGISTER:   pin_value = reg_val;
         dgl_pkg::SRC_FORWARD:    pin_value = fwd;
         dgl_pkg::SRC_FRAME_SYNC: pin_value = fsync;
         dgl_pkg::SRC_INT_CTRL:   pin_value = ctrl;
      endcase
   endfunction : pin_value

   // Value carried by a back-channel slot; unused codes send low.
   function automatic logic slot_value(input logic [3:0] code, input logic [7:0] lvl,
                                       input logic fsi, input logic fse);
      if (code[3] == 1'b0)
         slot_value = lvl[code[2:0]];
      else if (code == dgl_pkg::SLOT_INT_FSYNC)
         slot_value = fsi;
      else if (code == dgl_pkg::SLOT_EXT_FSYNC)
         slot_value = fse;
      else
         slot_value = 1'b0;
   endfunction : slot_value

   // Serial control target.
   dgl_i2c_target #(
      .DEV_ADDR (DEV_ADDR)
   ) u_i2c (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .scl_in    (scl_in),
      .sda_in    (sda_in),
      .sda_out   (sda_out),
      .sda_oe    (sda_oe),
      .reg_req   (reg_req),
      .rd_addr   (rd_addr),
      .reg_rdata (reg_rdata)
   );

   // Write decode.
   assign wr_input    = reg_req.wr && reg_req.addr == dgl_pkg::OFF_PIN_INPUT_DISABLE;
   assign wr_pulldown = reg_req.wr && reg_req.addr == dgl_pkg::OFF_PIN_PULLDOWN_DIS;
   assign wr_port_sel = reg_req.wr && reg_req.addr == dgl_pkg::OFF_RX_PORT_SELECT;
   assign wr_pin_ctl  = reg_req.wr && reg_req.addr >= dgl_pkg::OFF_PIN0_OUTPUT_CONTROL
                        && reg_req.addr <= dgl_pkg::OFF_PIN7_OUTPUT_CONTROL;
   assign wr_slot_lo  = reg_req.wr && reg_req.addr == dgl_pkg::OFF_SLOT_MAP_LOW;
   assign wr_slot_hi  = reg_req.wr && reg_req.addr == dgl_pkg::OFF_SLOT_MAP_HIGH;

   // Read data; the open-drain pin has no disable bits, so they read zero.
   always_comb
   begin
      reg_rdata = 8'h00;
      if (rd_addr == dgl_pkg::OFF_PIN_LEVEL_STATUS)
         reg_rdata = pin_level_status;
      else if (rd_addr == dgl_pkg::OFF_PIN_INPUT_DISABLE)
         reg_rdata = input_disable;
      else if (rd_addr == dgl_pkg::OFF_PIN_PULLDOWN_DIS)
         reg_rdata = pulldown_disable;
      else if (rd_addr == dgl_pkg::OFF_RX_PORT_SELECT)
         reg_rdata = {6'h00, port_select};
      else if (rd_addr >= dgl_pkg::OFF_PIN0_OUTPUT_CONTROL
               && rd_addr <= dgl_pkg::OFF_PIN7_OUTPUT_CONTROL)
         reg_rdata = pin_ctl[rd_addr[2:0]];
      else if (rd_addr == dgl_pkg::OFF_SLOT_MAP_LOW)
         reg_rdata = slot_map[{port_select, 1'b0}];
      else if (rd_addr == dgl_pkg::OFF_SLOT_MAP_HIGH)
         reg_rdata = slot_map[{port_select, 1'b1}];
   end

   // Control registers.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         input_disable    <= dgl_pkg::RST_INPUT_DISABLE;
         pulldown_disable <= dgl_pkg::RST_PULLDOWN_DISABLE;
         port_select      <= dgl_pkg::RST_PORT_SELECT;
         for (int k = 0; k < dgl_pkg::NUM_PINS; k++)
         begin
            pin_ctl[k]  <= dgl_pkg::RST_PIN_CTL;
            slot_map[k] <= dgl_pkg::RST_SLOT_MAP;
         end
      end
      else
      begin
         if (wr_input)
            input_disable <= reg_req.wdata & ~OD_MASK;
         if (wr_pulldown)
            pulldown_disable <= reg_req.wdata & ~OD_MASK;
         if (wr_port_sel)
            port_select <= reg_req.wdata[1:0];
         if (wr_pin_ctl)
            pin_ctl[reg_req.addr[2:0]] <= reg_req.wdata;
         if (wr_slot_lo)
            slot_map[{port_select, 1'b0}] <= reg_req.wdata;
         if (wr_slot_hi)
            slot_map[{port_select, 1'b1}] <= reg_req.wdata;
      end
   end

   // Per-pin output path; the open-drain pin only ever pulls low.
   for (genvar i = 0; i < dgl_pkg::NUM_PINS; i++)
   begin : g_pin
      wire [3:0] fidx = {pin_ctl[i][dgl_pkg::CTL_FWD_PORT_LSB +: 2],
                         pin_ctl[i][dgl_pkg::CTL_FWD_IDX_LSB +: 2]};
      wire       val  = pin_value(pin_ctl[i][dgl_pkg::CTL_SRC_LSB +: 2],
                                  pin_ctl[i][dgl_pkg::CTL_OUT_VAL_BIT],
                                  fwd_gpio[fidx], frame_sync_pulse,
                                  internal_ctrl);
      wire       oe   = pin_ctl[i][dgl_pkg::CTL_OUT_EN_BIT];
      if (i == dgl_pkg::OPEN_DRAIN_PIN)
      begin : g_od
         assign next_pin_out[i]         = 1'b0;
         assign next_pin_oe[i]          = oe & ~val;
         assign next_pin_input_en[i]    = 1'b1;
         assign next_pin_pulldown_en[i] = 1'b1;
      end
      else
      begin : g_pp
         assign next_pin_out[i]         = val;
         assign next_pin_oe[i]          = oe;
         assign next_pin_input_en[i]    = ~input_disable[i];
         assign next_pin_pulldown_en[i] = ~pulldown_disable[i];
      end
   end

   // Back-channel slots hold their value between frames of their own port.
   for (genvar p = 0; p < dgl_pkg::NUM_PORTS; p++)
   begin : g_port
      for (genvar s = 0; s < dgl_pkg::NUM_SLOTS; s++)
      begin : g_slot
         wire [3:0] code = slot_map[p * 2 + s / 2][(s % 2) * dgl_pkg::SLOT_FIELD_W +: 4];
         assign next_bc_gpio[p * 4 + s] = bc_frame_strobe[p]
            ? slot_value(code, pin_level_status, frame_sync_pulse, frame_sync_ext)
            : bc_gpio[p * 4 + s];
      end
   end

   // Pin and link outputs; one register stage keeps forward latency fixed.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         pin_out          <= 8'h00;
         pin_oe           <= 8'h00;
         pin_input_en     <= 8'hff;
         pin_pulldown_en  <= 8'hff;
         pin_level_status <= 8'h00;
         bc_gpio          <= 16'h0000;
      end
      else
      begin
         pin_out          <= next_pin_out;
         pin_oe           <= next_pin_oe;
         pin_input_en     <= next_pin_input_en;
         pin_pulldown_en  <= next_pin_pulldown_en;
         pin_level_status <= pin_in;
         bc_gpio          <= next_bc_gpio;
      end
   end

   reset_default_a: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(resetn) |-> (pin_oe == 8'h00 && pin_input_en == 8'hff))
      else $error("Pins not idle inputs after reset.");

   open_drain_a: assert property (@(posedge core_clk) disable iff (!resetn)
      pin_input_en[3] && pin_pulldown_en[3] && !pin_out[3])
      else $error("Open-drain pin has wrong fixed controls.");

   input_enable_a: assert property (@(posedge core_clk) disable iff (!resetn)
      ##1 ((pin_input_en & ~OD_MASK) == (~$past(input_disable) & ~OD_MASK)))
      else $error("Input enable does not follow its disable bit.");

   pulldown_a: assert property (@(posedge core_clk) disable iff (!resetn)
      ##1 ((pin_pulldown_en & ~OD_MASK) == (~$past(pulldown_disable) & ~OD_MASK)))
      else $error("Pulldown does not follow its disable bit.");

   pin_status_a: assert property (@(posedge core_clk) disable iff (!resetn)
      ##1 (pin_level_status == $past(pin_in)))
      else $error("Status register lost the pin level.");

   output_enable_a: assert property (@(posedge core_clk) disable iff (!resetn)
      $rose(pin_ctl[0][0]) |=> pin_oe[0] ##0 $past(wr_pin_ctl, 2))
      else $error("Pin 0 output enable did not follow its control.");

   fsync_route_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (pin_ctl[7][0] && pin_ctl[7][3:2] == 2'b10)
      |=> (pin_oe[7] && pin_out[7] == $past(frame_sync_pulse)))
      else $error("Frame sync not routed to pin 7.");

   fwd_route_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (pin_ctl[7][3:2] == 2'b01)
      |=> pin_out[7] == $past(fwd_gpio[{pin_ctl[7][5:4], pin_ctl[7][7:6]}]))
      else $error("Forward value not routed to pin 7.");

   bc_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
      !bc_frame_strobe[0] |=> $stable(bc_gpio[3:0]))
      else $error("Slot value changed outside its frame.");

   bc_fsync_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (bc_frame_strobe[1] && slot_map[3][3:0] == dgl_pkg::SLOT_INT_FSYNC)
      |=> bc_gpio[6] == $past(frame_sync_pulse))
      else $error("Internal frame sync not sent on port 1 slot 2.");

   bc_pin_a: assert property (@(posedge core_clk) disable iff (!resetn)
      (bc_frame_strobe[1] && !slot_map[2][3])
      |=> bc_gpio[4] == $past(pin_level_status[slot_map[2][2:0]]))
      else $error("Pin level not sent on port 1 slot 0.");

endmodule : dgl_pin_mapper

// ==== logic/dgl_pkg.sv ====
// Shared constants, field layouts and carrier types of the pin mapper block.
package dgl_pkg;

   // Block dimensions.
   localparam int NUM_PINS       = 8;
   localparam int NUM_PORTS      = 4;
   localparam int NUM_SLOTS      = 4;
   localparam int OPEN_DRAIN_PIN = 3;

   // Register offsets on the control interface.
   localparam logic [7:0] OFF_RX_PORT_SELECT      = 8'h0c;
   localparam logic [7:0] OFF_PIN_LEVEL_STATUS    = 8'h0e;
   localparam logic [7:0] OFF_PIN_INPUT_DISABLE   = 8'h0f;
   localparam logic [7:0] OFF_PIN0_OUTPUT_CONTROL = 8'h10;
   localparam logic [7:0] OFF_PIN7_OUTPUT_CONTROL = 8'h17;
   localparam logic [7:0] OFF_SLOT_MAP_LOW        = 8'h6e;
   localparam logic [7:0] OFF_SLOT_MAP_HIGH       = 8'h6f;
   localparam logic [7:0] OFF_PIN_PULLDOWN_DIS    = 8'hbe;

   // Fields of each pin_output_control register.
   localparam int CTL_OUT_EN_BIT   = 0;
   localparam int CTL_OUT_VAL_BIT  = 1;
   localparam int CTL_SRC_LSB      = 2;
   localparam int CTL_FWD_PORT_LSB = 4;
   localparam int CTL_FWD_IDX_LSB  = 6;

   // Back-channel slot field: four bits per slot, two slots per register.
   localparam int         SLOT_FIELD_W   = 4;
   localparam logic [3:0] SLOT_INT_FSYNC = 4'h8;
   localparam logic [3:0] SLOT_EXT_FSYNC = 4'h9;

   // Reset values.
   localparam logic [7:0] RST_INPUT_DISABLE    = 8'h00;
   localparam logic [7:0] RST_PULLDOWN_DISABLE = 8'h00;
   localparam logic [7:0] RST_PIN_CTL          = 8'h00;
   localparam logic [7:0] RST_SLOT_MAP         = 8'h00;
   localparam logic [1:0] RST_PORT_SELECT      = 2'h0;

   // Output source of a pin.
   typedef enum logic [1:0] {
      SRC_REGISTER   = 2'b00,
      SRC_FORWARD    = 2'b01,
      SRC_FRAME_SYNC = 2'b10,
      SRC_INT_CTRL   = 2'b11
   } dgl_src_type;

   // Serial control target states and byte phases.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX   = 3'b001,
      ST_ACK  = 3'b010,
      ST_TX   = 3'b011,
      ST_RACK = 3'b100
   } dgl_i2c_state_type;

   typedef enum logic [1:0] {
      PH_ADDR = 2'b00,
      PH_PTR  = 2'b01,
      PH_DATA = 2'b10
   } dgl_phase_type;

   // Register write request from the serial target.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
   } dgl_reg_req_type;

endpackage : dgl_pkg

// ==== logic/dgl_i2c_target.sv ====
// Serial control target that turns bus transfers into register reads and writes.
`timescale 1ns/100ps
module dgl_i2c_target #(
   parameter logic [6:0] DEV_ADDR = 7'h30
) (
   // Clock and reset.
   input  wire logic                    core_clk,
   input  wire logic                    resetn,
   // Serial bus pins; data is open drain.
   input  wire logic                    scl_in,
   input  wire logic                    sda_in,
   output      logic                    sda_out,
   output      logic                    sda_oe,
   // Register side.
   output      dgl_pkg::dgl_reg_req_type reg_req,
   output      logic [7:0]              rd_addr,
   input  wire logic [7:0]              reg_rdata
);

   logic                        scl_q;
   logic                        sda_q;
   logic                        scl_p;
   logic                        sda_p;
   dgl_pkg::dgl_i2c_state_type  state;
   dgl_pkg::dgl_phase_type      phase;
   logic                        rw;
   logic                        ack_ok;
   logic [3:0]                  cnt;
   logic [7:0]                  shreg;
   logic [7:0]                  ptr;
   logic                        drive_low;
   wire                         start_seen;
   wire                         stop_seen;
   wire                         scl_rise;
   wire                         scl_fall;

   // Bus conditions from the sampled pins and their previous values.
   assign start_seen = scl_q & scl_p & sda_p & ~sda_q;
   assign stop_seen  = scl_q & scl_p & ~sda_p & sda_q;
   assign scl_rise   = scl_q & ~scl_p;
   assign scl_fall   = ~scl_q & scl_p;
   assign sda_out    = 1'b0;   // Open drain: only ever pulls low.
   assign sda_oe     = drive_low;
   assign rd_addr    = ptr;

   // Pin sampling.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end
      else
      begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         scl_p <= scl_q;
         sda_p <= sda_q;
      end
   end

   // Byte engine; a start is honoured in any state so a stuck transfer recovers.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state     <= dgl_pkg::ST_IDLE;
         phase     <= dgl_pkg::PH_ADDR;
         rw        <= 1'b0;
         ack_ok    <= 1'b0;
         cnt       <= 4'h0;
         shreg     <= 8'h00;
         ptr       <= 8'h00;
         drive_low <= 1'b0;
         reg_req   <= '0;
      end
      else
      begin
         reg_req.wr <= 1'b0;
         if (start_seen)
         begin
            state     <= dgl_pkg::ST_RX;
            phase     <= dgl_pkg::PH_ADDR;
            cnt       <= 4'h0;
            drive_low <= 1'b0;
         end
         else if (stop_seen)
         begin
            state     <= dgl_pkg::ST_IDLE;
            drive_low <= 1'b0;
         end
         else
         begin
            unique case (state)
               dgl_pkg::ST_IDLE: ;
               dgl_pkg::ST_RX:
                  if (scl_rise && cnt != 4'h8)
                  begin
                     shreg <= {shreg[6:0], sda_q};
                     cnt   <= 4'(cnt + 4'h1);
                  end
                  else if (scl_fall && cnt == 4'h8)
                  begin
                     cnt <= 4'h0;
                     if (phase == dgl_pkg::PH_ADDR && shreg[7:1] != DEV_ADDR)
                        state <= dgl_pkg::ST_IDLE;
                     else
                     begin
                        drive_low <= 1'b1;
                        state     <= dgl_pkg::ST_ACK;
                        if (phase == dgl_pkg::PH_ADDR)
                           rw <= shreg[0];
                        else if (phase == dgl_pkg::PH_PTR)
                        begin
                           ptr   <= shreg;
                           phase <= dgl_pkg::PH_DATA;
                        end
                        else
                        begin
                           reg_req <= '{addr: ptr, wdata: shreg, wr: 1'b1};
                           ptr     <= 8'(ptr + 8'h01);
                        end
                     end
                  end
               dgl_pkg::ST_ACK:
                  if (scl_fall)
                  begin
                     if (phase == dgl_pkg::PH_ADDR && rw)
                     begin
                        shreg     <= reg_rdata;
                        drive_low <= ~reg_rdata[7];
                        ptr       <= 8'(ptr + 8'h01);
                        cnt       <= 4'h1;
                        phase     <= dgl_pkg::PH_DATA;
                        state     <= dgl_pkg::ST_TX;
                     end
                     else
                     begin
                        drive_low <= 1'b0;
                        state     <= dgl_pkg::ST_RX;
                        if (phase == dgl_pkg::PH_ADDR)
                           phase <= dgl_pkg::PH_PTR;
                     end
                  end
               dgl_pkg::ST_TX:
                  if (scl_fall)
                  begin
                     if (cnt == 4'h8)
                     begin
                        drive_low <= 1'b0;
                        state     <= dgl_pkg::ST_RACK;
                     end
                     else
                     begin
                        drive_low <= ~shreg[6];
                        shreg     <= {shreg[6:0], 1'b0};
                        cnt       <= 4'(cnt + 4'h1);
                     end
                  end
               dgl_pkg::ST_RACK:
                  if (scl_rise)
                     ack_ok <= ~sda_q;
                  else if (scl_fall)
                  begin
                     if (ack_ok)
                     begin
                        shreg     <= reg_rdata;
                        drive_low <= ~reg_rdata[7];
                        ptr       <= 8'(ptr + 8'h01);
                        cnt       <= 4'h1;
                        state     <= dgl_pkg::ST_TX;
                     end
                     else
                        state <= dgl_pkg::ST_IDLE;
                  end
               default: state <= dgl_pkg::ST_IDLE;
            endcase
         end
      end
   end

endmodule : dgl_i2c_target

// ==== sim/dgl_serializer_model.sv ====
// Remote serializer stand-in: back-channel frame strobes and forward values.
`timescale 1ns/100ps
module dgl_serializer_model (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        resetn,
   // Forward source levels and link outputs.
   input  wire logic [15:0] fwd_val,
   output      logic [15:0] fwd_gpio,
   output      logic [3:0]  bc_frame_strobe
);
   logic [2:0] cnt;
   // A frame every eight cycles; forward values only move once a frame.
   always_ff @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt             <= 3'h0;
         fwd_gpio        <= 16'h0000;
         bc_frame_strobe <= 4'h0;
      end
      else
      begin
         cnt             <= cnt + 3'h1;
         bc_frame_strobe <= {4{cnt == 3'h7}};
         if (cnt == 3'h0)
            fwd_gpio <= fwd_val;
      end
   end
endmodule : dgl_serializer_model

// ==== sim/test_dgl_pin_mapper.sv ====
// Self-checking bench for the pin mapper through its serial control port.
`timescale 1ns/100ps
module test_dgl_pin_mapper;
   logic        core_clk = 1'b0, resetn = 1'b0, scl = 1'b1, sda_m = 1'b1;
   logic        sda_out, sda_oe, sda_line, fsi = 1'b0, fse = 1'b0, ictl = 1'b0;
   logic [7:0]  ext = 8'h00, pin_in, pin_out, pin_oe, in_en, pd_en, rd;
   logic [15:0] fwd_val = 16'h0000, fwd_gpio, bc_gpio;
   logic [3:0]  strobe;
   logic [7:0]  tbl [3] = '{8'he5, 8'h09, 8'h0d};
   int          fail_count = 0, checks = 0, cyc = 0;
   // Data wire has a pull-up; a pad shows its driver, else the outside level.
   assign sda_line = sda_m & ~sda_oe;
   assign pin_in   = (pin_oe & pin_out) | (~pin_oe & ext);
   always #50 core_clk = ~core_clk;
   dgl_pin_mapper dgl_pin_mapper_i (.core_clk(core_clk), .resetn(resetn), .scl_in(scl),
      .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_input_en(in_en), .pin_pulldown_en(pd_en),
      .fwd_gpio(fwd_gpio), .frame_sync_pulse(fsi), .frame_sync_ext(fse),
      .internal_ctrl(ictl), .bc_frame_strobe(strobe), .bc_gpio(bc_gpio));
   dgl_serializer_model dgl_serializer_model_i (.core_clk(core_clk), .resetn(resetn),
      .fwd_val(fwd_val), .fwd_gpio(fwd_gpio), .bc_frame_strobe(strobe));
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #10;
   endtask : tick
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // One bus bit; the wire is sampled while the clock is high.
   task automatic bit_io(input logic b, output logic s);
      sda_m = b;
      tick(4);
      scl = 1'b1;
      tick(4);
      s = sda_line;
      scl = 1'b0;
      tick(4);
   endtask : bit_io
   task automatic start;
      sda_m = 1'b1;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_m = 1'b0;
      tick(4);
      scl = 1'b0;
      tick(4);
   endtask : start
   task automatic stop;
      sda_m = 1'b0;
      tick(4);
      scl = 1'b1;
      tick(4);
      sda_m = 1'b1;
      tick(4);
   endtask : stop
   task automatic tx(input logic [7:0] b);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(b[i], a);
      bit_io(1'b1, a);
      chk("ack", 16'h0000, {15'h0000, a});
   endtask : tx
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start;
      tx(8'h60);
      tx(a);
      tx(d);
      stop;
      tick(2);
   endtask : wr
   // Pointer write, repeated start, one byte read and refused.
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic s;
      start;
      tx(8'h60);
      tx(a);
      start;
      tx(8'h61);
      for (int i = 7; i >= 0; i--) bit_io(1'b1, rd[i]);
      bit_io(1'b1, s);
      stop;
      chk("reg", {8'h00, e}, {8'h00, rd});
   endtask : rdc
   task automatic end_sim;
      if (fail_count == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   // A hang is cut short well past the expected run length.
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         fail_count++;
         end_sim;
      end
   end
   initial
   begin
      tick(2);
      resetn = 1'b1;
      tick(1);
      chk("pin_oe", 16'h0000, {8'h00, pin_oe});
      chk("in_en", 16'h00ff, {8'h00, in_en});
      chk("pd_en", 16'h00ff, {8'h00, pd_en});
      chk("sda_out", 16'h0000, {15'h0000, sda_out});
      rdc(8'h0f, 8'h00);
      rdc(8'hbe, 8'h00);
      ext = 8'ha5;
      rdc(8'h0e, 8'ha5);
      wr(8'h0f, 8'h06);
      chk("in_en", 16'h00f9, {8'h00, in_en});
      wr(8'h0f, 8'hff);
      chk("in_en", 16'h0008, {8'h00, in_en});
      wr(8'hbe, 8'hff);
      chk("pd_en", 16'h0008, {8'h00, pd_en});
      rdc(8'hbe, 8'hf7);
      for (int i = 0; i < 8; i++) wr(8'h10 + i[7:0], {6'h00, ~i[0], 1'b1});
      chk("pin_oe", 16'h00ff, {8'h00, pin_oe});
      chk("pin_out", 16'h0055, {8'h00, pin_out});
      rdc(8'h0e, 8'h55);
      // Selected source toggles against the other live inputs and the register value stays 0, so a wrong pick shows.
      for (int k = 0; k < 3; k++)
         for (int v = 0; v < 2; v++)
         begin
            fwd_val = (k == 0) ? (16'h0800 ^ {16{~v[0]}}) : {16{~v[0]}};
            fsi = (k == 1) ? v[0] : ~v[0];
            ictl = (k == 2) ? v[0] : ~v[0];
            wr(8'h17, tbl[k]);
            chk("pin7", {15'h0000, v[0]}, {15'h0000, pin_out[7]});
         end
      wr(8'h0c, 8'h01);
      wr(8'h6e, 8'h44);
      wr(8'h6f, 8'h98);
      rdc(8'h6e, 8'h44);
      fsi = 1'b1;
      fse = 1'b0;
      tick(20);
      chk("bc_gpio", 16'hff7f, bc_gpio);
      fsi = 1'b0;
      fse = 1'b1;
      tick(20);
      chk("bc_gpio", 16'hffbf, bc_gpio);
      end_sim;
   end
endmodule : test_dgl_pin_mapper
